// ==== core/pisc_pkg.sv ====
// shared constants and types for the panel input sync conditioning block
package pisc_pkg;

    // register byte offsets
    localparam logic [11:0] PISC_OFS_TCTL = 12'h400;
    localparam logic [11:0] PISC_OFS_OCTL = 12'h404;
    localparam logic [11:0] PISC_OFS_STAT = 12'h408;

    // reset values
    localparam logic [31:0] PISC_TCTL_RST = 32'h0000_0000;
    localparam logic [31:0] PISC_OCTL_RST = 32'h0000_0000;

    // writable bits: 30, 29, 27 and 7:0
    localparam logic [31:0] PISC_TCTL_MASK = 32'h6800_00FF;
    // writable bits: 26, 24, 23, 22
    localparam logic [31:0] PISC_OCTL_MASK = 32'h05C0_0000;

    // field positions of the timing control word
    localparam int PISC_BIT_FRAME_POL = 30;
    localparam int PISC_BIT_LINE_POL = 29;
    localparam int PISC_BIT_SRC_SEL = 27;
    localparam int PISC_LSB_LEAD = 5;
    localparam int PISC_LSB_TRAIL = 0;

    // leading edge codes above zero skip a one-clock delay
    localparam logic [3:0] PISC_LEAD_SKIP = 4'h1;
    // last position the edge counter reaches
    localparam logic [4:0] PISC_POS_LAST = 5'h1F;

    // bus responses
    localparam logic [1:0] PISC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PISC_RESP_SLVERR = 2'h2;

    // input timing control word
    typedef struct packed {
        logic rsv31;
        logic frame_sync_in_polarity;
        logic line_sync_in_polarity;
        logic rsv28;
        logic line_sync_source_select;
        logic [18:0] rsv26_8;
        logic [2:0] lead_pos;
        logic [4:0] trail_pos;
    } pisc_tctl_s;

    // output timing control word
    typedef struct packed {
        logic [4:0] rsv31_27;
        logic line_out_pol_en;
        logic rsv25;
        logic frame_out_pol_en;
        logic frame_out_pol;
        logic line_out_pol;
        logic [21:0] rsv21_0;
    } pisc_octl_s;

    // synchroniser and filter state of one sync pin
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } pisc_sync_s;

endpackage

// ==== core/pisc_panel_input_sync.sv ====
// panel input sync conditioning with axi4-lite register access
// Notes on behaviour
// - each sync input is inverted when its polarity bit is one
// - internal logic triggers on rising edge of the conditioned pulse
// - frame polarity bit: 0 idles low pulses high, 1 idles high pulses low
// - line polarity bit: 0 idles low pulses high, 1 idles high pulses low
// - source bit zero passes conditioned line sync straight to output
// - source bit one rebuilds the line pulse from edge position fields
// - generated pulse triggered by input, polarity from separate control bit
// - leading position counted in pixel clocks from conditioned rising edge
// - leading code zero means no delay and is the default
// - leading codes one to seven give delays of two to eight clocks
// - leading field is ignored unless the source bit is set
// - zero or negative programmed length produces no output pulse
// - output frame polarity follows only its own control and enable bits
// - output line polarity follows only its own control and enable bits, and only while the source bit is set
// - timing control register resets to zero and is read/write
// - trailing field delays trailing edge by its value; zero gives no pulse
// - output line polarity acts only while its enable bit is set
//
// Added by the designer: the AXI4-Lite slave port.
module pisc_panel_input_sync
    import pisc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk_i, // pixel clock, 125 MHz
    input wire logic sys_rst_i, // synchronous reset, high
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic frame_sync_in_i, // frame sync from source pin
    input wire logic line_sync_in_i, // line sync from source pin
    output logic frame_sync_out_o, // frame sync to panel
    output logic line_pulse_out_o // line pulse to panel
);

    // word-aligned address match
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        addr_hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs));
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [31:0] m);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        merge = r & m;
    endfunction

    // leading code to delay in clocks, no code gives one
    function automatic logic [4:0] lead_delay(input logic [2:0] code);
        logic [3:0] d;
        d = (code == 3'h0) ? 4'h0 : ({1'b0, code} + PISC_LEAD_SKIP);
        lead_delay = {1'b0, d};
    endfunction

    // register state
    pisc_tctl_s tctl_reg;
    pisc_octl_s octl_reg;
    pisc_sync_s fsync_reg;
    pisc_sync_s lsync_reg;
    logic lcond_d_reg;
    logic [4:0] cnt_reg;
    logic run_reg;
    logic gen_reg;
    logic frame_out_reg;
    logic line_out_reg;

    // bus state
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // handshakes and write decode
    wire aw_hs = s_axi_awvalid & awready_reg;
    wire w_hs = s_axi_wvalid & wready_reg;
    wire wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
    wire b_hs = bvalid_reg & s_axi_bready;
    wire ar_hs = s_axi_arvalid & arready_reg;
    wire r_hs = rvalid_reg & s_axi_rready;
    wire wr_tctl = wr_fire & addr_hit(awaddr_reg, PISC_OFS_TCTL);
    wire wr_octl = wr_fire & addr_hit(awaddr_reg, PISC_OFS_OCTL);
    wire wr_ok = wr_tctl | wr_octl;

    // read decode; status is read-only
    wire rd_tctl = addr_hit(s_axi_araddr, PISC_OFS_TCTL);
    wire rd_octl = addr_hit(s_axi_araddr, PISC_OFS_OCTL);
    wire rd_stat = addr_hit(s_axi_araddr, PISC_OFS_STAT);
    wire rd_ok = rd_tctl | rd_octl | rd_stat;
    wire [31:0] stat_word = {27'h0, line_out_reg, gen_reg, run_reg, lsync_reg.level, fsync_reg.level};
    wire [31:0] rd_word = rd_tctl ? 32'(tctl_reg) :
                          rd_octl ? 32'(octl_reg) :
                          rd_stat ? stat_word : 32'h0000_0000;

    wire fcond = fsync_reg.level ^ tctl_reg.frame_sync_in_polarity;
    wire lcond = lsync_reg.level ^ tctl_reg.line_sync_in_polarity;

    // edge found on the pixel clock
    wire ledge = lcond & ~lcond_d_reg;

    // lead field used only in generated mode
    wire [4:0] lead_dly = tctl_reg.line_sync_source_select ? lead_delay(tctl_reg.lead_pos) : 5'h00;
    wire [4:0] trail = tctl_reg.trail_pos;
    // position zero is the detect cycle
    wire [4:0] pos = ledge ? 5'h00 : cnt_reg;
    wire active = ledge | run_reg;
    // empty or inverted window gives nothing
    wire win_ok = (trail != 5'h00) & (trail > lead_dly);
    wire gen_next = active & win_ok & (pos >= lead_dly) & (pos < trail);

    wire line_inv = octl_reg.line_out_pol_en & octl_reg.line_out_pol;
    // output frame inversion, own bits only
    wire frame_inv = octl_reg.frame_out_pol_en & octl_reg.frame_out_pol;
    wire line_out_next = tctl_reg.line_sync_source_select ? (gen_next ^ line_inv) : lcond;
    wire frame_out_next = fcond ^ frame_inv;

    // pin synchronisers: stage 0 feeds only stage 1
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            fsync_reg <= '0;
            lsync_reg <= '0;
        end else begin
            fsync_reg.stage <= {fsync_reg.stage[1:0], frame_sync_in_i};
            lsync_reg.stage <= {lsync_reg.stage[1:0], line_sync_in_i};
            // level moves only once stages one and two agree
            if (fsync_reg.stage[1] == fsync_reg.stage[2]) begin
                fsync_reg.level <= fsync_reg.stage[2];
            end
            if (lsync_reg.stage[1] == lsync_reg.stage[2]) begin
                lsync_reg.level <= lsync_reg.stage[2];
            end
        end
    end

    // edge detect history
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            lcond_d_reg <= 1'b0;
        end else begin
            lcond_d_reg <= lcond;
        end
    end

    // position counter, restarts on every edge
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 5'h00;
            run_reg <= 1'b0;
        end else if (ledge) begin
            cnt_reg <= 5'h01;
            run_reg <= 1'b1;
        end else if (run_reg) begin
            // stop at the last position the trailing field can reach
            if (cnt_reg == PISC_POS_LAST) begin
                run_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // output flops, so pins never glitch on mode changes
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            gen_reg <= 1'b0;
            line_out_reg <= 1'b0;
            frame_out_reg <= 1'b0;
        end else begin
            gen_reg <= gen_next;
            line_out_reg <= line_out_next;
            frame_out_reg <= frame_out_next;
        end
    end

    // control registers reset to zero, read/write
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tctl_reg <= pisc_tctl_s'(PISC_TCTL_RST);
            octl_reg <= pisc_octl_s'(PISC_OCTL_RST);
        end else begin
            if (wr_tctl) begin
                tctl_reg <= pisc_tctl_s'(merge(32'(tctl_reg), wdata_reg, wstrb_reg, PISC_TCTL_MASK));
            end
            if (wr_octl) begin
                octl_reg <= pisc_octl_s'(merge(32'(octl_reg), wdata_reg, wstrb_reg, PISC_OCTL_MASK));
            end
        end
    end

    // write address and data capture, either order
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_hs) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    // write channel flags; readies stay low until the response is taken
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_got_reg <= 1'b1;
                awready_reg <= 1'b0;
            end else if (wr_fire) begin
                aw_got_reg <= 1'b0;
            end else if (b_hs | (~aw_got_reg & ~bvalid_reg)) begin
                awready_reg <= 1'b1;
            end
            if (w_hs) begin
                w_got_reg <= 1'b1;
                wready_reg <= 1'b0;
            end else if (wr_fire) begin
                w_got_reg <= 1'b0;
            end else if (b_hs | (~w_got_reg & ~bvalid_reg)) begin
                wready_reg <= 1'b1;
            end
        end
    end

    // write response, error for unmapped or read-only words
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= PISC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? PISC_RESP_OKAY : PISC_RESP_SLVERR;
        end else if (b_hs) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read channel, one read outstanding
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= PISC_RESP_OKAY;
        end else if (ar_hs) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_ok ? PISC_RESP_OKAY : PISC_RESP_SLVERR;
        end else if (r_hs) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end else if (~rvalid_reg) begin
            arready_reg <= 1'b1;
        end
    end

    // port drive, all from flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign frame_sync_out_o = frame_out_reg;
    assign line_pulse_out_o = line_out_reg;

endmodule

// ==== tb/pisc_panel_input_sync_properties.sv ====
// bus handshake and reset checks for the panel input sync block
module pisc_panel_input_sync_properties
    import pisc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // in
    input wire logic s_axi_awvalid, // in
    input wire logic s_axi_awready, // in
    input wire logic s_axi_wvalid, // in
    input wire logic s_axi_wready, // in
    input wire logic [1:0] s_axi_bresp, // in
    input wire logic s_axi_bvalid, // in
    input wire logic s_axi_bready, // in
    input wire logic [ADDR_W-1:0] s_axi_araddr, // in
    input wire logic s_axi_arvalid, // in
    input wire logic s_axi_arready, // in
    input wire logic [31:0] s_axi_rdata, // in
    input wire logic [1:0] s_axi_rresp, // in
    input wire logic s_axi_rvalid, // in
    input wire logic s_axi_rready, // in
    input wire logic line_pulse_out_o // in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_map;
    logic aw_go;
    logic ar_go;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // decode and handshake terms
    assign rd_map = s_axi_araddr inside {PISC_OFS_TCTL, PISC_OFS_OCTL, PISC_OFS_STAT};
    assign aw_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    assign ar_go = s_axi_arvalid & s_axi_arready;
    property p_aw_block; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("awready stayed high");
    property p_b_answer; aw_go |-> ##2 s_axi_bvalid; endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_ar_block; ar_go |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read answer wrong");
    property p_rd_bad; ar_go && !rd_map |=> s_axi_rresp == PISC_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read accepted");
    property p_wr_stat; aw_go && s_axi_awaddr == PISC_OFS_STAT |-> ##2 s_axi_bresp == PISC_RESP_SLVERR; endproperty
    a_wr_stat: assert property (p_wr_stat) else $error("status write accepted");
    property p_rst; disable iff (1'b0) sys_rst_i |=> !s_axi_bvalid && !s_axi_rvalid && !line_pulse_out_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
    c_write: cover property (aw_go);
    c_bad_read: cover property (ar_go && !rd_map);
    c_pulse: cover property ($rose(line_pulse_out_o));
endmodule

bind pisc_panel_input_sync pisc_panel_input_sync_properties #(.ADDR_W(ADDR_W)) pisc_props_i (
    .sys_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_pulse_out_o
);

// ==== tb/pisc_sync_source.sv ====
// upstream source model driving the two sync pins
module pisc_sync_source (
    input wire logic sys_clk_i, // clock
    input wire logic frame_pol_i, // frame idles high
    input wire logic line_pol_i, // line idles high
    input wire logic frame_go_i, // start frame pulse
    input wire logic line_go_i, // start line pulse
    input wire logic [4:0] width_i, // pulse length
    output logic frame_sync_o, // frame pin
    output logic line_sync_o // line pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] f_left = 5'h00;
    logic [4:0] l_left = 5'h00;
    // count down the active part of each pulse
    always @(posedge sys_clk_i) begin
        f_left <= frame_go_i ? width_i : f_left - {4'h0, f_left != 5'h00};
        l_left <= line_go_i ? width_i : l_left - {4'h0, l_left != 5'h00};
    end
    assign frame_sync_o = frame_pol_i ^ (f_left != 5'h00);
    assign line_sync_o = line_pol_i ^ (l_left != 5'h00);
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the panel input sync block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pisc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic frame_sync_in_i, line_sync_in_i, frame_sync_out_o, line_pulse_out_o;
    logic frame_pol = 1'b0;
    logic line_pol = 1'b0;
    logic frame_go = 1'b0;
    logic line_go = 1'b0;
    logic [4:0] width = 5'h00;
    int n_errors = 0;
    int checks = 0;
    // 125 MHz pixel clock
    always #4 sys_clk_i = ~sys_clk_i;
    pisc_panel_input_sync #(.ADDR_W(12)) pisc_panel_input_sync_i (
        .sys_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_sync_in_i,
        .line_sync_in_i, .frame_sync_out_o, .line_pulse_out_o
    );
    pisc_sync_source pisc_sync_source_i (
        .sys_clk_i, .frame_pol_i(frame_pol), .line_pol_i(line_pol), .frame_go_i(frame_go),
        .line_go_i(line_go), .width_i(width), .frame_sync_o(frame_sync_in_i), .line_sync_o(line_sync_in_i)
    );
    task automatic end_of_test;
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    // bounded wait; running out ends the run
    task automatic bound(input int n);
        if (n == 40) begin
            n_errors++;
            end_of_test();
        end
    endtask
    // one write; each channel released at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb, rv;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        tb = 1'b0;
        for (int n = 0; !tb; n++) begin
            bound(n);
            @(negedge sys_clk_i);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            rv = s_axi_bvalid;
            tb = rv & s_axi_bready;
            r = s_axi_bresp;
            @(posedge sys_clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            // ready trails the response a cycle so the slave must hold it
            s_axi_bready <= rv & ~tb;
        end
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr, rv;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        tr = 1'b0;
        for (int n = 0; !tr; n++) begin
            bound(n);
            @(negedge sys_clk_i);
            ta = s_axi_arvalid & s_axi_arready;
            rv = s_axi_rvalid;
            tr = rv & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge sys_clk_i);
            if (ta) s_axi_arvalid <= 1'b0;
            // ready trails the data a cycle so the slave must hold it
            s_axi_rready <= rv & ~tr;
        end
        @(posedge sys_clk_i);
    endtask
    // one source pulse; counts output cycles away from idle
    task automatic fire(input bit ln, input logic [4:0] w, output int f, output int cnt, output logic idl);
        @(negedge sys_clk_i);
        idl = ln ? line_pulse_out_o : frame_sync_out_o;
        f = -1;
        cnt = 0;
        @(posedge sys_clk_i);
        width <= w;
        if (ln) line_go <= 1'b1;
        else frame_go <= 1'b1;
        @(posedge sys_clk_i);
        line_go <= 1'b0;
        frame_go <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            @(negedge sys_clk_i);
            if ((ln ? line_pulse_out_o : frame_sync_out_o) !== idl) begin
                if (f < 0) f = i;
                cnt++;
            end
        end
        @(posedge sys_clk_i);
    endtask
    function automatic int lead(int c);
        return (c == 0) ? 0 : c + 1;
    endfunction
    function automatic int gen_len(int c, int t);
        return (t > lead(c)) ? t - lead(c) : 0;
    endfunction
    initial begin
        logic [31:0] v, d;
        logic [1:0] r;
        int f0, f, cnt, w, c, t;
        logic idl;
        void'($urandom(44));
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rd(PISC_OFS_TCTL, d, r);
        chk("tctl reset", PISC_TCTL_RST, d);
        for (int k = 0; k < 5; k++) begin
            v = $urandom();
            wr(PISC_OFS_TCTL, v, r);
            chk("tctl bresp", 32'(PISC_RESP_OKAY), 32'(r));
            rd(PISC_OFS_TCTL, d, r);
            chk("tctl", v & PISC_TCTL_MASK, d);
        end
        // partial write: only the low byte lane lands
        s_axi_wstrb <= 4'h1;
        wr(PISC_OFS_TCTL, ~v, r);
        s_axi_wstrb <= 4'hF;
        rd(PISC_OFS_TCTL, d, r);
        chk("tctl strobe", {v[31:8], ~v[7:0]} & PISC_TCTL_MASK, d);
        // unmapped and read-only places refuse
        wr(12'h40C, 32'hFFFF_FFFF, r);
        chk("unmapped bresp", 32'(PISC_RESP_SLVERR), 32'(r));
        wr(PISC_OFS_STAT, 32'hFFFF_FFFF, r);
        chk("status bresp", 32'(PISC_RESP_SLVERR), 32'(r));
        rd(12'h40C, d, r);
        chk("unmapped rresp", 32'(PISC_RESP_SLVERR), 32'(r));
        // bypass in both input polarities, edge fields set but ignored
        for (int p = 0; p < 2; p++) begin
            frame_pol <= p[0];
            line_pol <= p[0];
            wr(PISC_OFS_TCTL, {1'b0, p[0], p[0], 21'h0, 8'($urandom())}, r);
            repeat (40) @(posedge sys_clk_i);
            w = $urandom_range(15, 6);
            fire(1'b1, 5'(w), f, cnt, idl);
            chk("bypass width", 32'(w), 32'(cnt));
            chk("bypass idle", 32'h0, 32'(idl));
            fire(1'b0, 5'(w), f, cnt, idl);
            chk("frame width", 32'(w), 32'(cnt));
            chk("frame idle", 32'h0, 32'(idl));
            rd(PISC_OFS_STAT, d, r);
            chk("status levels", {30'h0, p[0], p[0]}, d);
        end
        // generated pulse: every lead code, random trail, no-pulse corners
        for (int k = 0; k < 12; k++) begin
            c = (k == 9) ? 3 : k % 8;
            t = (k == 0) ? 20 : (k == 8) ? 0 : (k == 9) ? 4 : $urandom_range(31, 1);
            line_pol <= k[0];
            wr(PISC_OFS_TCTL, {2'b01, k[0], 2'b01, 19'h0, 3'(c), 5'(t)}, r);
            repeat (40) @(posedge sys_clk_i);
            fire(1'b1, 5'h0C, f, cnt, idl);
            if (k == 0) f0 = f;
            chk("gen width", 32'(gen_len(c, t)), 32'(cnt));
            if (cnt > 0) chk("gen delay", 32'(lead(c)), 32'(f - f0));
            chk("gen idle", 32'h0, 32'(idl));
        end
        // line output polarity acts only with its enable; frame polarity is only set together with its enable
        for (int k = 0; k < 2; k++) begin
            line_pol <= 1'b0;
            wr(PISC_OFS_OCTL, k ? 32'h05C0_0000 : 32'h0040_0000, r);
            wr(PISC_OFS_TCTL, 32'h4800_004A, r);
            repeat (40) @(posedge sys_clk_i);
            fire(1'b1, 5'h0C, f, cnt, idl);
            chk("line out idle", 32'(k), 32'(idl));
            chk("line out width", 32'h7, 32'(cnt));
            fire(1'b0, 5'h09, f, cnt, idl);
            chk("frame out idle", 32'(k), 32'(idl));
        end
        end_of_test();
    end
endmodule
